// *** hdl/mq_flags_pkg.sv ***
// constants, widths and register map for the queue flag block
package mq_flags_pkg;
	typedef enum logic [1:0] {W36, W18, W9} port_width_t;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] QUEUES_OFFSET = 8'h08;
	// control fields
	localparam int         CTRL_FLAG_EN_BIT = 0;
	localparam int         CTRL_WR_EN_BIT   = 1;
	localparam int         CTRL_RD_EN_BIT   = 2;
	localparam logic [2:0] CTRL_RESET       = 3'h7;
	// status fields
	localparam int STAT_WQ_LSB  = 0;
	localparam int STAT_RQ_LSB  = 4;
	localparam int STAT_WW_LSB  = 8;
	localparam int STAT_RW_LSB  = 10;
	localparam int STAT_FF_BIT  = 12;
	localparam int STAT_OV_BIT  = 13;
	localparam int STAT_CFG_BIT = 14;
	localparam int QUEUES_EMPTY_LSB = 8;
	// queue address layout
	localparam int QSEL_W   = 6;
	localparam int QLOW_W   = 3;
	localparam int CHIP_W   = 3;
	// occupancy counted in bytes of nine bits
	localparam logic [2:0] UNITS_X36 = 3'h4;
	localparam logic [2:0] UNITS_X18 = 3'h2;
	localparam logic [2:0] UNITS_X9  = 3'h1;
	// read pipeline depth from queue select to new data
	localparam int RD_SWITCH_CYCLES = 2;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : mq_flags_pkg

// *** hdl/qstat_if.sv ***
// occupancy update and status carrier between flag logic and counters
`timescale 1ns/100ps
interface qstat_if #(
	parameter int NQ = 8
);
	logic          wr_push;
	logic [2:0]    wr_q;
	logic [2:0]    wr_units;
	logic          rd_pop;
	logic [2:0]    rd_q;
	logic [2:0]    rd_units;
	logic [NQ-1:0] full_vec;
	logic [NQ-1:0] avail_vec;
	modport flags (output wr_push, wr_q, wr_units, rd_pop, rd_q, rd_units,
		input full_vec, avail_vec);
	modport counters (input wr_push, wr_q, wr_units, rd_pop, rd_q, rd_units,
		output full_vec, avail_vec);
endinterface : qstat_if

// *** hdl/queue_status.sv ***
// per-queue occupancy counters with full and data-available status
`timescale 1ns/100ps
module queue_status #(
	parameter int NQ    = 8,
	parameter int DEPTH = 2048
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// updates and status
	qstat_if.counters q
);
	localparam int CW = $clog2(DEPTH * 4 + 1);
	localparam logic [CW-1:0] CAP = CW'(DEPTH * 4);

	logic [CW-1:0] cnt_reg [NQ];
	logic [CW-1:0] cnt_next [NQ];

	always_comb begin
		for (int i = 0; i < NQ; i++) begin
			cnt_next[i] = cnt_reg[i];
			// both ports may touch one queue in the same cycle
			if (q.wr_push && q.wr_q == 3'(i))
				cnt_next[i] = cnt_next[i] + CW'(q.wr_units); // RULE_20
			if (q.rd_pop && q.rd_q == 3'(i))
				cnt_next[i] = cnt_next[i] - CW'(q.rd_units); // RULE_11
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NQ; i++)
				cnt_reg[i] <= '0;
		end else begin
			for (int i = 0; i < NQ; i++)
				cnt_reg[i] <= cnt_next[i];
		end
	end

	always_comb begin
		for (int i = 0; i < NQ; i++) begin
			// full means one more write-port word would not fit
			q.full_vec[i]  = (cnt_reg[i] + CW'(q.wr_units)) > CAP; // RULE_03
			// valid data means a whole read-port word is stored
			q.avail_vec[i] = cnt_reg[i] >= CW'(q.rd_units); // RULE_04
		end
	end
endmodule : queue_status

// *** hdl/mq_flags.sv ***
// active-queue full and output-valid flags with bus-matched widths
//
// Contract
// RULE_01 - width match off gives x36 both; on, selects pick the narrow port
// RULE_02 - width pins are caught at reset and fix both port widths
// RULE_03 - full state counts in write-port word units
// RULE_04 - valid state counts in read-port word units
// RULE_05 - write select is six bits: low three queue, high three chip
// RULE_06 - full kept per queue, only selected write queue drives the flag
// RULE_07 - full flag shows new queue one write edge after selection
// RULE_08 - first write to a new queue on the second edge after selection
// RULE_09 - controller checks full before writing and skips full queues
// RULE_10 - full flag changes only on rising clock edges
// RULE_11 - reads update a queue's full state even when not write-selected
// RULE_12 - full flag driven only when upper write select bits match chip code
// RULE_13 - controller joins full flags and writes one device at a time
// RULE_14 - valid flag updates on the edge loading the output register
// RULE_15 - empty kept per queue, valid flag reflects selected read queue
// RULE_16 - after last word, next enabled read makes valid flag inactive
// RULE_17 - new queue data and valid flag appear two cycles after select
// RULE_18 - previous queue words keep flowing until new queue data arrives
// RULE_19 - valid flag changes only on rising clock edges
// RULE_20 - writes make a queue non-empty even when not read-selected
// RULE_21 - valid flag driven only when upper read select bits match chip code
// RULE_22 - controller joins valid flags and reads one device at a time
// RULE_23 - both flags active low
// RULE_24 - read queue chosen by select bus with strobe on a rising edge
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module mq_flags #(
	parameter int NQ    = 8,
	parameter int DEPTH = 2048
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// write port pins
	input  wire logic [5:0]  write_queue_select,
	input  wire logic        write_select_strobe,
	input  wire logic        write_en_n,
	// read port pins
	input  wire logic [5:0]  read_queue_select,
	input  wire logic        read_select_strobe,
	input  wire logic        read_en_n,
	// set-up straps
	input  wire logic        width_match_enable,
	input  wire logic        input_width_select,
	input  wire logic        output_width_select,
	input  wire logic        chip_code_bit0,
	input  wire logic        chip_code_bit1,
	input  wire logic        chip_code_bit2,
	// flag pins
	output logic             write_queue_full_n,
	output logic             write_queue_full_n_oe,
	output logic             read_word_valid_n,
	output logic             read_word_valid_n_oe,
	output logic [2:0]       read_word_queue,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	localparam int PW = 19;

	function automatic logic [2:0] units(input mq_flags_pkg::port_width_t w);
		case (w)
			mq_flags_pkg::W18: units = mq_flags_pkg::UNITS_X18;
			mq_flags_pkg::W9:  units = mq_flags_pkg::UNITS_X9;
			default:           units = mq_flags_pkg::UNITS_X36;
		endcase
	endfunction : units

	qstat_if #(.NQ(NQ)) qs ();

	queue_status #(.NQ(NQ), .DEPTH(DEPTH)) counters (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.q       (qs.counters)
	);

	// pin synchronisers: all pins pass two flops before use
	logic [PW-1:0] pin_raw;
	logic [PW-1:0] pin_s1_reg;
	logic [PW-1:0] pin_s2_reg;
	assign pin_raw = {write_queue_select, write_select_strobe, write_en_n,
		read_queue_select, read_select_strobe, read_en_n,
		width_match_enable, input_width_select, output_width_select};

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	logic [5:0] wsel_in;
	logic       wstb_in;
	logic       wen_n_in;
	logic [5:0] rsel_in;
	logic       rstb_in;
	logic       ren_n_in;
	logic       bm_in;
	logic       iw_in;
	logic       ow_in;
	assign {wsel_in, wstb_in, wen_n_in, rsel_in, rstb_in, ren_n_in,
		bm_in, iw_in, ow_in} = pin_s2_reg;

	// chip code is static, still passed through two flops
	logic [2:0] chip_s1_reg;
	logic [2:0] chip_reg;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			chip_s1_reg <= '0;
			chip_reg    <= '0;
		end else begin
			chip_s1_reg <= {chip_code_bit2, chip_code_bit1, chip_code_bit0};
			chip_reg    <= chip_s1_reg;
		end
	end

	// width straps: caught once, after the synchroniser has filled
	logic [1:0]                  cfg_wait_reg, cfg_wait_next;
	logic                        cfg_done_reg, cfg_done_next;
	mq_flags_pkg::port_width_t   ww_reg, ww_next, rw_reg, rw_next;

	always_comb begin
		cfg_wait_next = cfg_wait_reg;
		cfg_done_next = cfg_done_reg;
		ww_next       = ww_reg;
		rw_next       = rw_reg;
		if (!cfg_done_reg) begin
			cfg_wait_next = cfg_wait_reg + 2'h1;
			if (cfg_wait_reg == 2'h2) begin
				cfg_done_next = 1'b1; // RULE_02
				ww_next = mq_flags_pkg::W36; // RULE_01
				rw_next = mq_flags_pkg::W36;
				if (bm_in && !iw_in)
					rw_next = ow_in ? mq_flags_pkg::W9 : mq_flags_pkg::W18;
				else if (bm_in)
					ww_next = ow_in ? mq_flags_pkg::W9 : mq_flags_pkg::W18;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_wait_reg <= '0;
			cfg_done_reg <= 1'b0;
			ww_reg       <= mq_flags_pkg::W36;
			rw_reg       <= mq_flags_pkg::W36;
		end else begin
			cfg_wait_reg <= cfg_wait_next;
			cfg_done_reg <= cfg_done_next;
			ww_reg       <= ww_next;
			rw_reg       <= rw_next;
		end
	end

	logic [2:0] ctrl_reg, ctrl_next;

	// write side
	logic [5:0] wsel_reg, wsel_next;
	logic       ff_n_reg, ff_n_next;
	logic       ff_oe_reg, ff_oe_next;
	logic       wr_hit;

	always_comb begin
		wsel_next = wsel_reg;
		if (wstb_in)
			wsel_next = wsel_in; // RULE_05
		// flag follows the registered select, so it lags selection by one
		ff_n_next  = !qs.full_vec[wsel_reg[2:0]]; // RULE_06 RULE_07 RULE_23
		ff_oe_next = ctrl_reg[mq_flags_pkg::CTRL_FLAG_EN_BIT] &&
			wsel_reg[5:3] == chip_reg; // RULE_12
	end

	// a write one edge after select lands in the new queue on the second
	assign wr_hit = cfg_done_reg && !wen_n_in &&
		wsel_reg[5:3] == chip_reg && !qs.full_vec[wsel_reg[2:0]] &&
		ctrl_reg[mq_flags_pkg::CTRL_WR_EN_BIT]; // RULE_08 RULE_09

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wsel_reg  <= '0;
			ff_n_reg  <= 1'b1;
			ff_oe_reg <= 1'b0;
		end else begin
			wsel_reg  <= wsel_next;
			ff_n_reg  <= ff_n_next; // RULE_10
			ff_oe_reg <= ff_oe_next;
		end
	end

	// read side: select stage, active queue, output register
	logic [5:0] rsel_reg, rsel_next;
	logic       rpend_reg, rpend_next;
	logic [5:0] ract_reg, ract_next;
	logic       ov_n_reg, ov_n_next;
	logic       ov_oe_reg, ov_oe_next;
	logic [2:0] rq_out_reg, rq_out_next;
	logic       rd_load;
	logic       rd_take;

	// the register refills when empty or when the held word is read
	assign rd_take = ov_n_reg || !ren_n_in;
	assign rd_load = cfg_done_reg && rd_take &&
		ract_reg[5:3] == chip_reg && qs.avail_vec[ract_reg[2:0]] &&
		ctrl_reg[mq_flags_pkg::CTRL_RD_EN_BIT];

	always_comb begin
		rsel_next   = rsel_reg;
		rpend_next  = 1'b0;
		ract_next   = ract_reg;
		ov_n_next   = ov_n_reg;
		rq_out_next = rq_out_reg;
		if (rstb_in) begin
			rsel_next  = rsel_in; // RULE_24
			rpend_next = 1'b1;
		end
		// old queue stays active until one edge after select
		if (rpend_reg)
			ract_next = rsel_reg; // RULE_17 RULE_18
		if (rd_take) begin
			ov_n_next   = !rd_load; // RULE_14 RULE_15 RULE_16 RULE_23
			rq_out_next = ract_reg[2:0];
		end
		ov_oe_next = ctrl_reg[mq_flags_pkg::CTRL_FLAG_EN_BIT] &&
			rsel_reg[5:3] == chip_reg; // RULE_21
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsel_reg   <= '0;
			rpend_reg  <= 1'b0;
			ract_reg   <= '0;
			ov_n_reg   <= 1'b1;
			ov_oe_reg  <= 1'b0;
			rq_out_reg <= '0;
		end else begin
			rsel_reg   <= rsel_next;
			rpend_reg  <= rpend_next;
			ract_reg   <= ract_next;
			ov_n_reg   <= ov_n_next; // RULE_19
			ov_oe_reg  <= ov_oe_next;
			rq_out_reg <= rq_out_next;
		end
	end

	assign qs.wr_push  = wr_hit; // RULE_20
	assign qs.wr_q     = wsel_reg[2:0];
	assign qs.wr_units = units(ww_reg); // RULE_03
	assign qs.rd_pop   = rd_load; // RULE_11
	assign qs.rd_q     = ract_reg[2:0];
	assign qs.rd_units = units(rw_reg); // RULE_04

	assign write_queue_full_n    = ff_n_reg;
	assign write_queue_full_n_oe = ff_oe_reg;
	assign read_word_valid_n     = ov_n_reg;
	assign read_word_valid_n_oe  = ov_oe_reg;
	assign read_word_queue       = rq_out_reg;

	// axi4-lite slave, one write and one read at a time
	logic        aw_got_reg, aw_got_next;
	logic        w_got_reg, w_got_next;
	logic [7:0]  awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0]  wstrb_reg, wstrb_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        awready_reg, awready_next;
	logic        wready_reg, wready_next;
	logic        arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;

	always_comb begin
		aw_got_next = aw_got_reg;
		w_got_next  = w_got_reg;
		awaddr_next = awaddr_reg;
		wdata_next  = wdata_reg;
		wstrb_next  = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		ctrl_next   = ctrl_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_got_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_got_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (aw_got_reg && w_got_reg && !bvalid_reg) begin
			aw_got_next = 1'b0;
			w_got_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = mq_flags_pkg::AXI_OKAY;
			if (awaddr_reg == mq_flags_pkg::CTRL_OFFSET) begin
				if (wstrb_reg[0])
					ctrl_next = wdata_reg[2:0];
			end else if (awaddr_reg != mq_flags_pkg::STATUS_OFFSET &&
				awaddr_reg != mq_flags_pkg::QUEUES_OFFSET)
				bresp_next = mq_flags_pkg::AXI_SLVERR;
		end
		awready_next = !aw_got_next && !bvalid_next;
		wready_next  = !w_got_next && !bvalid_next;
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = mq_flags_pkg::AXI_OKAY;
			rdata_next  = '0;
			case (s_axi_araddr)
				mq_flags_pkg::CTRL_OFFSET: rdata_next[2:0] = ctrl_reg;
				mq_flags_pkg::STATUS_OFFSET: begin
					rdata_next[mq_flags_pkg::STAT_WQ_LSB +: 6] = wsel_reg;
					rdata_next[mq_flags_pkg::STAT_RQ_LSB +: 3] = ract_reg[2:0];
					rdata_next[mq_flags_pkg::STAT_WW_LSB +: 2] = ww_reg;
					rdata_next[mq_flags_pkg::STAT_RW_LSB +: 2] = rw_reg;
					rdata_next[mq_flags_pkg::STAT_FF_BIT]  = ff_n_reg;
					rdata_next[mq_flags_pkg::STAT_OV_BIT]  = ov_n_reg;
					rdata_next[mq_flags_pkg::STAT_CFG_BIT] = cfg_done_reg;
				end
				mq_flags_pkg::QUEUES_OFFSET: begin
					rdata_next[NQ-1:0] = qs.full_vec;
					rdata_next[mq_flags_pkg::QUEUES_EMPTY_LSB +: NQ] =
						~qs.avail_vec;
				end
				default: rresp_next = mq_flags_pkg::AXI_SLVERR;
			endcase
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= '0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= '0;
			ctrl_reg    <= mq_flags_pkg::CTRL_RESET;
		end else begin
			aw_got_reg  <= aw_got_next;
			w_got_reg   <= w_got_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			ctrl_reg    <= ctrl_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
endmodule : mq_flags

// *** bench/mq_flags_asserts.sv ***
// concurrent checks on the queue flag block pins and register bus
`timescale 1ns/100ps
module mq_flags_asserts (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// queue pins
	input wire logic [5:0]  write_queue_select,
	input wire logic        write_select_strobe,
	input wire logic [5:0]  read_queue_select,
	input wire logic        read_select_strobe,
	input wire logic        read_en_n,
	input wire logic        chip_code_bit0,
	input wire logic        chip_code_bit1,
	input wire logic        chip_code_bit2,
	// flags
	input wire logic        write_queue_full_n_oe,
	input wire logic        read_word_valid_n,
	input wire logic        read_word_valid_n_oe,
	input wire logic [2:0]  read_word_queue,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire [2:0] code = {chip_code_bit2, chip_code_bit1, chip_code_bit0};
	// pins pass two sync flops, hence the extra two cycles
	property p_ff_oe_on;
		write_select_strobe && write_queue_select[5:3] == code
			|-> ##4 write_queue_full_n_oe;
	endproperty
	a_ff_oe_on: assert property (p_ff_oe_on)
		else $error("full flag not driven for own chip");
	property p_ff_oe_off;
		write_select_strobe && write_queue_select[5:3] != code
			|-> ##4 !write_queue_full_n_oe;
	endproperty
	a_ff_oe_off: assert property (p_ff_oe_off)
		else $error("full flag driven for other chip");
	property p_ov_oe_on;
		read_select_strobe && read_queue_select[5:3] == code
			|-> ##4 read_word_valid_n_oe;
	endproperty
	a_ov_oe_on: assert property (p_ov_oe_on)
		else $error("valid flag not driven for own chip");
	property p_ov_oe_off;
		read_select_strobe && read_queue_select[5:3] != code
			|-> ##4 !read_word_valid_n_oe;
	endproperty
	a_ov_oe_off: assert property (p_ov_oe_off)
		else $error("valid flag driven for other chip");
	property p_rd_switch;
		read_select_strobe && read_queue_select[5:3] == code && !read_en_n
			##1 (!read_select_strobe && !read_en_n)[*4]
			|=> read_word_valid_n
			|| read_word_queue == $past(read_queue_select[2:0], 5);
	endproperty
	a_rd_switch: assert property (p_rd_switch)
		else $error("new queue word late after read switch");
	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat)
		else $error("write response late");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop)
		else $error("write response held after taken");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat)
		else $error("read data late");
	property p_r_drop;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_drop: assert property (p_r_drop)
		else $error("read data held after taken");
endmodule : mq_flags_asserts

bind mq_flags mq_flags_asserts u_asserts (.ref_clk, .rst_b,
	.write_queue_select, .write_select_strobe, .read_queue_select,
	.read_select_strobe, .read_en_n, .chip_code_bit0, .chip_code_bit1,
	.chip_code_bit2, .write_queue_full_n_oe, .read_word_valid_n,
	.read_word_valid_n_oe, .read_word_queue, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready);

// *** bench/sys_ctrl_model.sv ***
// system controller model driving the queue write and read pins
`timescale 1ns/100ps
module sys_ctrl_model (
	// clock and joined full flag
	input wire logic   ref_clk,
	input wire logic   full_bus_n,
	// pins toward the queue block
	output logic [5:0] write_queue_select,
	output logic       write_select_strobe,
	output logic       write_en_n,
	output logic [5:0] read_queue_select,
	output logic       read_select_strobe,
	output logic       read_en_n
);
	initial begin
		write_queue_select  = 6'h00;
		write_select_strobe = 1'b0;
		write_en_n          = 1'b1;
		read_queue_select   = 6'h00;
		read_select_strobe  = 1'b0;
		read_en_n           = 1'b1;
	end
	// one strobed edge picks a queue; only one chip is addressed at a time
	task sel_w(input logic [2:0] q, input logic [2:0] chip);
		@(posedge ref_clk);
		write_queue_select  <= {chip, q};
		write_select_strobe <= 1'b1;
		@(posedge ref_clk);
		write_select_strobe <= 1'b0;
	endtask : sel_w
	task sel_r(input logic [2:0] q, input logic [2:0] chip);
		@(posedge ref_clk);
		read_queue_select  <= {chip, q};
		read_select_strobe <= 1'b1;
		@(posedge ref_clk);
		read_select_strobe <= 1'b0;
	endtask : sel_r
	// one word at a time: the pin sync delay would let a burst overrun
	task wr(input int n);
		repeat (n) begin
			repeat (4) @(posedge ref_clk);
			if (full_bus_n) begin
				write_en_n <= 1'b0;
				@(posedge ref_clk);
				write_en_n <= 1'b1;
			end
		end
	endtask : wr
	task ren(input logic v);
		@(posedge ref_clk);
		read_en_n <= v;
	endtask : ren
	task rd(input int n);
		repeat (n) begin
			ren(1'b0);
			ren(1'b1);
		end
	endtask : rd
endmodule : sys_ctrl_model

// *** bench/mq_flags_tb.sv ***
// self-checking bench for the queue flag block
`timescale 1ns/100ps
module multiqueue_full_valid_flags_tb;
	localparam logic [2:0] CODE = 3'h5;
	localparam logic [7:0] QREG = mq_flags_pkg::QUEUES_OFFSET;
	logic ref_clk, rst_b, full_bus_n, write_en_n, read_en_n;
	logic width_match_enable, input_width_select, output_width_select;
	logic [5:0] write_queue_select, read_queue_select;
	logic write_select_strobe, read_select_strobe;
	logic write_queue_full_n, write_queue_full_n_oe, read_word_valid_n;
	logic [2:0] chip_code = CODE;
	logic [2:0] read_word_queue;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, read_word_valid_n_oe;
	int n_fail = 0;
	int comparisons = 0;
	// undriven flag wire is pulled up
	assign full_bus_n = write_queue_full_n_oe ? write_queue_full_n : 1'b1;
	mq_flags #(.DEPTH(4)) uut (.ref_clk, .rst_b, .write_queue_select,
		.write_select_strobe, .write_en_n, .read_queue_select,
		.read_select_strobe, .read_en_n, .width_match_enable,
		.input_width_select, .output_width_select,
		.chip_code_bit0(chip_code[0]), .chip_code_bit1(chip_code[1]),
		.chip_code_bit2(chip_code[2]), .write_queue_full_n,
		.write_queue_full_n_oe, .read_word_valid_n, .read_word_valid_n_oe,
		.read_word_queue, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	sys_ctrl_model ctl (.ref_clk, .full_bus_n, .write_queue_select,
		.write_select_strobe, .write_en_n, .read_queue_select,
		.read_select_strobe, .read_en_n);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task do_reset(input logic b, input logic i, input logic o);
		@(posedge ref_clk);
		rst_b               <= 1'b0;
		width_match_enable  <= b;
		input_width_select  <= i;
		output_width_select <= o;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (12) @(posedge ref_clk);
	endtask : do_reset
	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready && s_axi_awvalid)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready && s_axi_arvalid)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		chk(write_queue_full_n, 1'b1);
		chk(write_queue_full_n_oe, 1'b0);
		chk(read_word_valid_n, 1'b1);
		axi_rd(mq_flags_pkg::CTRL_OFFSET, d, r);
		chk(d, 32'(mq_flags_pkg::CTRL_RESET));
		axi_wr(mq_flags_pkg::CTRL_OFFSET, 32'h0000_0003, r);
		chk(r, 32'(mq_flags_pkg::AXI_OKAY));
		axi_rd(mq_flags_pkg::CTRL_OFFSET, d, r);
		chk(d, 32'h0000_0003);
		axi_wr(mq_flags_pkg::CTRL_OFFSET, 32'h0000_0007, r);
		axi_wr(8'h40, 32'h0000_00ff, r);
		chk(r, 32'(mq_flags_pkg::AXI_SLVERR));
		axi_rd(8'h40, d, r);
		chk(r, 32'(mq_flags_pkg::AXI_SLVERR));
		chk(d, 32'h0);
		$display("registers done");
	endtask : t_regs
	task t_straps;
		logic [31:0] d;
		logic [1:0]  r;
		logic [2:0]  s;
		mq_flags_pkg::port_width_t ww, rw;
		for (int k = 0; k < 5; k++) begin
			s = (k == 0) ? 3'h0 : {1'b1, 2'(k - 1)};
			ww = (!s[2] || !s[1]) ? mq_flags_pkg::W36
				: s[0] ? mq_flags_pkg::W9 : mq_flags_pkg::W18;
			rw = (!s[2] || s[1]) ? mq_flags_pkg::W36
				: s[0] ? mq_flags_pkg::W9 : mq_flags_pkg::W18;
			do_reset(s[2], s[1], s[0]);
			width_match_enable <= ~s[2];
			axi_rd(mq_flags_pkg::STATUS_OFFSET, d, r);
			chk(d[9:8], ww);
			chk(d[11:10], rw);
			chk(d[14], 1'b1);
		end
		$display("straps done");
	endtask : t_straps
	task t_fill;
		logic [31:0] d;
		logic [1:0]  r;
		do_reset(1'b1, 1'b0, 1'b1);
		ctl.sel_r(3'h0, CODE);
		ctl.sel_w(3'h1, CODE);
		ctl.wr(5);
		step(4);
		chk(write_queue_full_n, 1'b0);
		ctl.sel_w(3'h2, CODE);
		step(2);
		chk(write_queue_full_n, 1'b0);
		step(1);
		chk(write_queue_full_n, 1'b1);
		ctl.sel_r(3'h1, CODE);
		ctl.rd(2);
		step(6);
		axi_rd(QREG, d, r);
		chk(d[1], 1'b1);
		ctl.rd(2);
		step(6);
		axi_rd(QREG, d, r);
		chk(d[1], 1'b0);
		ctl.sel_w(3'h1, CODE);
		step(3);
		chk(write_queue_full_n, 1'b1);
		$display("full flag done");
	endtask : t_fill
	task t_valid;
		logic [31:0] d;
		logic [1:0]  r;
		do_reset(1'b1, 1'b1, 1'b1);
		ctl.sel_r(3'h0, CODE);
		ctl.sel_w(3'h3, CODE);
		ctl.wr(3);
		step(4);
		axi_rd(QREG, d, r);
		chk(d[11], 1'b1);
		ctl.wr(1);
		step(4);
		axi_rd(QREG, d, r);
		chk(d[11], 1'b0);
		chk(read_word_valid_n, 1'b1);
		ctl.ren(1'b0);
		ctl.sel_r(3'h3, CODE);
		step(3);
		chk(read_word_valid_n, 1'b1);
		step(1);
		chk(read_word_valid_n, 1'b0);
		chk(read_word_queue, 3'h3);
		step(1);
		chk(read_word_valid_n, 1'b1);
		ctl.ren(1'b1);
		$display("valid flag done");
	endtask : t_valid
	task t_expand;
		chip_code <= 3'h2;
		for (int c = 0; c < 8; c++) begin
			ctl.sel_w(3'h0, 3'(c));
			ctl.sel_r(3'h0, 3'(c));
			step(4);
			chk(write_queue_full_n_oe, 3'(c) == chip_code);
			chk(read_word_valid_n_oe, 3'(c) == chip_code);
		end
		$display("expansion done");
	endtask : t_expand
	initial begin
		rst_b = 1'b0;
		width_match_enable = 1'b0;
		input_width_select = 1'b0;
		output_width_select = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		do_reset(1'b0, 1'b0, 1'b0);
		t_regs;
		t_straps;
		t_fill;
		t_valid;
		t_expand;
		wrap_up;
	end
	// the tests need a few hundred cycles; this is over a hundred times that
	initial begin
		#400000;
		n_fail++;
		wrap_up;
	end
endmodule : multiqueue_full_valid_flags_tb
